// ---- shared/ccr_cfg.svh ----
/*
 Constants of the charger command registers: command codes, target address,
 field positions, reset values and set-point limits.
 Assumes inclusion by bare name from shared/.
*/
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Target address and command codes
`define CCR_TARGET_ADDR 7'h09
`define CCR_CMD_CTRL 8'h12
`define CCR_CMD_CURR 8'h14
`define CCR_CMD_VOLT 8'h15
`define CCR_CMD_ALARM 8'h16

// Control word fields
`define CCR_BIT_SUPPRESS 0
`define CCR_BIT_RESTORE 2
`define CCR_BIT_ATTACH_MASK 5
`define CCR_BIT_SUPPLY_MASK 6
`define CCR_BIT_HALT 10

// Reset and restore values
`define CCR_CTRL_RST 16'h0440
`define CCR_VOLT_RST 16'hfff0
`define CCR_CURR_RST 16'h000c
`define CCR_VOLT_RESTORE 16'hffff
`define CCR_CURR_RESTORE 16'h00c0

// Voltage and current limits
`define CCR_VOLT_MIN 16'h0010
`define CCR_DAC_FULL 10'h3ff
`define CCR_TRK_FULL 5'h1f
`define CCR_TRK_THRESH 16'h0020
`define CCR_CURR_MAX_GND 16'h03ff
`define CCR_CURR_MAX_OPEN 16'h07ff
`define CCR_CURR_MAX_VL 16'h0fff

`endif

// ---- shared/ccr_pkg.sv ----
/*
 Types of the charger command registers.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ccr_pkg;
	typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_CMD, SM_LOW, SM_HIGH, SM_SKIP} ccr_smb_state_t;
	typedef enum logic [1:0] {RNG_GND, RNG_OPEN, RNG_VL} ccr_range_t;
endpackage

// ---- shared/ccr_trk_if.sv ----
/*
 Settings and results passed between the register top and the
 trickle and switcher enable logic.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface ccr_trk_if;
	logic [15:0] currentWord;
	logic [15:0] voltageWord;
	logic suppressed;
	logic lockout;
	logic thermalStop;
	logic loopLow;
	logic notReg;
	logic [4:0] code;
	logic trickleOn;
	logic switcherOn;
	modport ctrl(output currentWord, voltageWord, suppressed, lockout, thermalStop, loopLow,
		notReg, input code, trickleOn, switcherOn);
	modport calc(input currentWord, voltageWord, suppressed, lockout, thermalStop, loopLow,
		notReg, output code, trickleOn, switcherOn);
endinterface
`default_nettype wire

// ---- rtl/ccr_sync.sv ----
/*
 Two-stage synchroniser for a group of asynchronous inputs.
 Assumes the inputs are levels that stay for several clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;

	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_r[i] <= 1'b0;
				syncOut[i] <= 1'b0;
			end else begin
				meta_r[i] <= asyncIn[i];
				syncOut[i] <= meta_r[i];
			end
		end
	end
endmodule // ccr_sync
`default_nettype wire

// ---- rtl/ccr_trickle.sv ----
/*
 Trickle source code and the two charge-path enables.
 Assumes settings arrive from registers on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"
module ccr_trickle import ccr_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Settings and results
	ccr_trk_if.calc trk
);
	logic kill;
	logic loopCut;
	logic big;

	// Any of these holds both paths off
	assign kill = trk.suppressed | trk.lockout | trk.thermalStop |
		(trk.currentWord == 16'h0000) | (trk.voltageWord < `CCR_VOLT_MIN);
	assign loopCut = trk.loopLow & ~trk.notReg;
	assign big = trk.currentWord >= `CCR_TRK_THRESH;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trk.code <= 5'h00;
			trk.trickleOn <= 1'b0;
			trk.switcherOn <= 1'b0;
		end else begin
			trk.trickleOn <= ~kill & ~loopCut;
			trk.switcherOn <= ~kill & big;
			if (kill || loopCut) begin
				trk.code <= 5'h00;
			end else if (big) begin
				trk.code <= `CCR_TRK_FULL;
			end else begin
				trk.code <= trk.currentWord[4:0];
			end
		end
	end

	AST_THERMAL_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		trk.thermalStop |=> trk.code == 5'h00 && !trk.trickleOn)
		else $error("Trickle source active during thermal stop");
	AST_FULL_SCALE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!kill && !loopCut && big) |=> trk.code == 5'h1f && trk.switcherOn)
		else $error("Large setting did not give full-scale trickle");
	AST_LOOP_CUT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(trk.loopLow && !trk.notReg) |=> trk.code == 5'h00)
		else $error("Trickle not shut off on voltage loop low");
	AST_ZERO_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		(trk.currentWord == 16'h0000 || trk.suppressed) |=> !trk.trickleOn && !trk.switcherOn)
		else $error("Charge path on with zero or suppressed setting");
endmodule // ccr_trickle
`default_nettype wire

// ---- rtl/ccr_top.sv ----
/*
 Command registers of a battery charger controller: a write-only SMBus
 target, the control, voltage and current words, and the derived outputs.
 Assumes SMBus pins and analog flags arrive asynchronously, and an external
 pad resolves the open-drain data line from smbDataOe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"

// Functional notes
// - control word written by write-word command 0x12, data bit 0 to bit 0
// - cell absent forces overtemp halt enable to one
// - voltage set point written by command 0x15, millivolts
// - voltage bits 3..0 ignored, bits 13..4 form the DAC code
// - bit 15 or 14 set forces DAC to all ones and flags overrange
// - voltage word resets to 0xfff0 and returns there while cell absent
// - current set point written by command 0x14, milliamps
// - range strap limits current to 1.023, 2.047 or 4.095 A
// - control bit 0 suppresses charging and sets the suppressed flag
// - control bit 2 restores settings and clears warm and lockout latches
// - bits 5 and 6 mask attach and supply-loss edge events
// - control bit 10 lets a warm sensor stop charging
// - thermal stop is warm and halt enable and not underrange
// - current 1..31 drives trickle directly, 32 and above full scale
// - voltage loop low without not-regulated shuts off the trickle
// - volts-not-regulated follows the internal clamp
// - trickle and switcher paths each get their own enable
// - answers only at target address 0x09, never starts a transfer
module ccr_top import ccr_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// SMBus pins
	input wire logic smbClkIn,
	input wire logic smbDataIn,
	output logic smbDataOut,
	output logic smbDataOe,
	// Analog status flags
	input wire logic cellAttachedIn,
	input wire logic warmSensorIn,
	input wire logic sensorUnderrangeIn,
	input wire logic voltLoopLowIn,
	input wire logic clampActiveIn,
	input wire logic supplyLossIn,
	input wire logic [1:0] rangeStrap,
	// Voltage path
	output logic [9:0] voltDacCode,
	output logic voltsOverrange,
	output logic voltsNotRegulated,
	// Current path
	output logic [15:0] currentLimit,
	output logic [4:0] trickleCode,
	output logic trickleOn,
	output logic switcherOn,
	// Status and events
	output logic chargingSuppressed,
	output logic overtempHaltEnable,
	output logic warmLatched,
	output logic alarmLockout,
	output logic thermalStop,
	output logic eventPulse
);
	logic [9:0] syncIn;
	logic [9:0] syncS;
	logic sclS;
	logic sdaS;
	logic cellS;
	logic warmS;
	logic urS;
	logic loopS;
	logic clampS;
	logic supS;
	ccr_range_t rangeS;
	logic sclD_r;
	logic sdaD_r;
	logic cellD_r;
	logic supD_r;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	ccr_smb_state_t state_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] lowByte_r;
	logic [7:0] cmd_r;
	logic ackOe_r;
	logic accept;
	logic wrStb_r;
	logic [7:0] wrCmd_r;
	logic [15:0] wrData_r;
	logic ctrlWr;
	logic restore;
	logic [15:0] ctrl_r;
	logic [15:0] volt_r;
	logic [15:0] curr_r;
	logic warm_r;
	logic alarm_r;
	logic [9:0] dac_r;
	logic ovr_r;
	logic noReg_r;
	logic event_r;
	logic [15:0] limit_r;
	logic [15:0] maxCurr;

	ccr_trk_if trk ();

	// All pins pass two flip-flops before any logic
	assign syncIn = {rangeStrap, supplyLossIn, clampActiveIn, voltLoopLowIn,
		sensorUnderrangeIn, warmSensorIn, cellAttachedIn, smbDataIn, smbClkIn};

	ccr_sync #(.W(10)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.asyncIn(syncIn),
		.syncOut(syncS)
	);

	assign sclS = syncS[0];
	assign sdaS = syncS[1];
	assign cellS = syncS[2];
	assign warmS = syncS[3];
	assign urS = syncS[4];
	assign loopS = syncS[5];
	assign clampS = syncS[6];
	assign supS = syncS[7];
	assign rangeS = ccr_range_t'(syncS[9:8]);

	// Edge history of the synchronised levels
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
			cellD_r <= 1'b0;
			supD_r <= 1'b0;
		end else begin
			sclD_r <= sclS;
			sdaD_r <= sdaS;
			cellD_r <= cellS;
			supD_r <= supS;
		end
	end

	assign sclRise = sclS & ~sclD_r;
	assign sclFall = ~sclS & sclD_r;
	assign startSeen = sclS & sclD_r & sdaD_r & ~sdaS;
	assign stopSeen = sclS & sclD_r & ~sdaD_r & sdaS;

	// Whether the byte just shifted in earns an acknowledge
	always_comb begin
		case (state_r)
			SM_ADDR: accept = shift_r == {`CCR_TARGET_ADDR, 1'b0};
			SM_CMD: accept = shift_r == `CCR_CMD_CTRL || shift_r == `CCR_CMD_CURR ||
				shift_r == `CCR_CMD_VOLT || shift_r == `CCR_CMD_ALARM;
			SM_LOW: accept = 1'b1;
			SM_HIGH: accept = 1'b1;
			default: accept = 1'b0;
		endcase
	end

	// Write-word target; reads are not acknowledged, so the line is never driven high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SM_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			lowByte_r <= 8'h00;
			cmd_r <= 8'h00;
			ackOe_r <= 1'b0;
			wrStb_r <= 1'b0;
			wrCmd_r <= 8'h00;
			wrData_r <= 16'h0000;
		end else begin
			wrStb_r <= 1'b0;
			if (startSeen) begin
				state_r <= SM_ADDR;
				bitCnt_r <= 4'h0;
				ackOe_r <= 1'b0;
			end else if (stopSeen) begin
				state_r <= SM_IDLE;
				ackOe_r <= 1'b0;
			end else if (state_r != SM_IDLE) begin
				if (sclRise) begin
					bitCnt_r <= bitCnt_r + 4'h1;
					if (bitCnt_r < 4'h8) begin
						shift_r <= {shift_r[6:0], sdaS};
					end
				end else if (sclFall && bitCnt_r == 4'h8) begin
					ackOe_r <= accept;
					if (accept && state_r == SM_CMD) begin
						cmd_r <= shift_r;
					end
					if (state_r == SM_LOW) begin
						lowByte_r <= shift_r;
					end
					if (state_r == SM_HIGH) begin
						wrStb_r <= 1'b1;
						wrCmd_r <= cmd_r;
						wrData_r <= {shift_r, lowByte_r};
					end
				end else if (sclFall && bitCnt_r == 4'h9) begin
					ackOe_r <= 1'b0;
					bitCnt_r <= 4'h0;
					case (state_r)
						SM_ADDR: state_r <= ackOe_r ? SM_CMD : SM_SKIP;
						SM_CMD: state_r <= ackOe_r ? SM_LOW : SM_SKIP;
						SM_LOW: state_r <= SM_HIGH;
						default: state_r <= SM_SKIP;
					endcase
				end
			end
		end
	end

	// Open-drain data: only ever pulled low
	assign smbDataOut = 1'b0;
	assign smbDataOe = ackOe_r;

	assign ctrlWr = wrStb_r && wrCmd_r == `CCR_CMD_CTRL;
	assign restore = ctrlWr && wrData_r[`CCR_BIT_RESTORE];

	// Control word; halt enable held at one while no cell is attached
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `CCR_CTRL_RST;
		end else begin
			if (ctrlWr) begin
				ctrl_r <= wrData_r;
			end
			if (!cellS) begin
				ctrl_r[`CCR_BIT_HALT] <= 1'b1;
			end
		end
	end

	// Voltage word
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			volt_r <= `CCR_VOLT_RST;
		end else if (!cellS) begin
			volt_r <= `CCR_VOLT_RST;
		end else if (restore) begin
			volt_r <= `CCR_VOLT_RESTORE;
		end else if (wrStb_r && wrCmd_r == `CCR_CMD_VOLT) begin
			volt_r <= wrData_r;
		end
	end

	// Current word; returns to its power-on value on removal
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			curr_r <= `CCR_CURR_RST;
		end else if (!cellS) begin
			curr_r <= `CCR_CURR_RST;
		end else if (restore) begin
			curr_r <= `CCR_CURR_RESTORE;
		end else if (wrStb_r && wrCmd_r == `CCR_CMD_CURR) begin
			curr_r <= wrData_r;
		end
	end

	// Latched flags: a new set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			warm_r <= 1'b0;
			alarm_r <= 1'b0;
		end else begin
			warm_r <= warmS | (warm_r & cellS & ~restore);
			alarm_r <= (wrStb_r && wrCmd_r == `CCR_CMD_ALARM &&
				(wrData_r[15] || wrData_r[14] || wrData_r[12])) |
				(alarm_r & cellS & ~restore);
		end
	end

	// Voltage DAC code and overrange
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_r <= `CCR_DAC_FULL;
			ovr_r <= 1'b1;
		end else if (volt_r[15] || volt_r[14]) begin
			dac_r <= `CCR_DAC_FULL;
			ovr_r <= 1'b1;
		end else begin
			dac_r <= volt_r[13:4];
			ovr_r <= 1'b0;
		end
	end

	// Strap picks the largest current the switcher may be asked for
	always_comb begin
		case (rangeS)
			RNG_GND: maxCurr = `CCR_CURR_MAX_GND;
			RNG_OPEN: maxCurr = `CCR_CURR_MAX_OPEN;
			RNG_VL: maxCurr = `CCR_CURR_MAX_VL;
			default: maxCurr = `CCR_CURR_MAX_OPEN;
		endcase
	end

	// Clamp status, current limit and masked edge events
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			noReg_r <= 1'b0;
			limit_r <= 16'h0000;
			event_r <= 1'b0;
		end else begin
			noReg_r <= clampS;
			limit_r <= (curr_r > maxCurr) ? maxCurr : curr_r;
			event_r <= (~ctrl_r[`CCR_BIT_ATTACH_MASK] & (cellS ^ cellD_r)) |
				(~ctrl_r[`CCR_BIT_SUPPLY_MASK] & (supS ^ supD_r));
		end
	end

	// Halt enable gates the warm flag; underrange means no usable sensor
	assign thermalStop = warm_r & ctrl_r[`CCR_BIT_HALT] & ~urS;

	assign trk.currentWord = curr_r;
	assign trk.voltageWord = volt_r;
	assign trk.suppressed = ctrl_r[`CCR_BIT_SUPPRESS];
	assign trk.lockout = alarm_r;
	assign trk.thermalStop = thermalStop;
	assign trk.loopLow = loopS;
	assign trk.notReg = noReg_r;

	ccr_trickle u_trickle (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.trk(trk)
	);

	assign voltDacCode = dac_r;
	assign voltsOverrange = ovr_r;
	assign voltsNotRegulated = noReg_r;
	assign currentLimit = limit_r;
	assign trickleCode = trk.code;
	assign trickleOn = trk.trickleOn;
	assign switcherOn = trk.switcherOn;
	assign chargingSuppressed = ctrl_r[`CCR_BIT_SUPPRESS];
	assign overtempHaltEnable = ctrl_r[`CCR_BIT_HALT];
	assign warmLatched = warm_r;
	assign alarmLockout = alarm_r;
	assign eventPulse = event_r;

	AST_CTRL_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrlWr && cellS) |=> ctrl_r == $past(wrData_r))
		else $error("Control word not loaded from write");
	AST_HALT_FORCED: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cellS |=> overtempHaltEnable)
		else $error("Halt enable not forced with cell absent");
	AST_VOLT_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wrStb_r && wrCmd_r == 8'h15 && cellS && !restore) |=> volt_r == $past(wrData_r))
		else $error("Voltage word not loaded");
	AST_DAC_CODE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!volt_r[15] && !volt_r[14]) |=> voltDacCode == $past(volt_r[13:4]) && !voltsOverrange)
		else $error("Voltage DAC code wrong");
	AST_OVERRANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(volt_r[15] || volt_r[14]) |=> voltDacCode == 10'h3ff && voltsOverrange)
		else $error("Overrange not forced");
	AST_VOLT_REMOVED: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cellS |=> volt_r == 16'hfff0 && curr_r == 16'h000c)
		else $error("Settings not restored on removal");
	AST_CURR_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wrStb_r && wrCmd_r == 8'h14 && cellS) |=> curr_r == $past(wrData_r))
		else $error("Current word not loaded");
	AST_RESTORE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(restore && cellS && !warmS) |=> volt_r == 16'hffff && curr_r == 16'h00c0 && !warm_r)
		else $error("Restore bit did not reload settings");
	AST_EVENT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cellS != cellD_r && !ctrl_r[5]) |=> eventPulse)
		else $error("Unmasked attach edge gave no event");
	AST_NOT_REG: assert property (@(posedge core_clk) disable iff (!rst_n)
		clampS |=> voltsNotRegulated)
		else $error("Not-regulated flag does not follow clamp");
	AST_QUIET_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_r == SM_IDLE || state_r == SM_SKIP) |-> !smbDataOe)
		else $error("Data line driven outside an addressed transfer");
endmodule // ccr_top
`default_nettype wire

// ---- dv/ccr_smb_host.sv ----
/*
 SMBus host model: open-drain master that sends write-word frames.
 Assumes the bench resolves the data wire and feeds its level back.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_smb_host (
	// Clock
	input wire logic core_clk,
	// Bus
	input wire logic sdaLevel,
	output logic sclOut,
	output logic sdaLow
);
	// Clock stands high between frames, data left to the pull-up
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Data moves a clock after SCL falls, so no false start or stop
	task automatic bit_out(input logic b, output logic rd);
		sclOut = 1'b0;
		tick(1);
		sdaLow = ~b;
		tick(3);
		sclOut = 1'b1;
		tick(2);
		rd = sdaLevel;
		tick(2);
	endtask
	task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
		input logic [15:0] d, output logic [3:0] acks);
		logic [7:0] by [4];
		logic r;
		by = '{{adr, 1'b0}, cmd, d[7:0], d[15:8]};
		sdaLow = 1'b1;
		tick(4);
		for (int k = 0; k < 4; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_out(by[k][i], r);
			end
			bit_out(1'b1, r);
			acks[3-k] = ~r;
		end
		bit_out(1'b0, r);
		sdaLow = 1'b0;
		tick(4);
	endtask
endmodule // ccr_smb_host
`default_nettype wire

// ---- dv/tb_charger_command_registers.sv ----
/*
 Self-checking bench of the charger command registers.
 Assumes the host model in dv/ and the design sources in rtl/ and shared/.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_charger_command_registers;
	logic core_clk, rst_n, cellIn, warmIn, underIn, loopIn, clampIn, lossIn;
	logic ovr, notReg, trkOn, swOn, supp, halt, warmL, lock, tStop, evt;
	logic sdaOut, sdaOe, scl, sdaLow, sda;
	logic [9:0] dac;
	logic [15:0] lim, curV, curC;
	logic [4:0] trk;
	logic [1:0] strap;
	int seed, err_count, checks_done;
	logic [15:0] vl [5] = '{16'h3ff0, 16'h4000, 16'h8000, 16'h1235, 16'h000f};
	logic [15:0] cl [5] = '{16'h0000, 16'h0001, 16'h001f, 16'h0020, 16'hffff};
	// Open-drain data wire with pull-up
	assign sda = ~(sdaLow | sdaOe);
	ccr_top u_ccr_top (.core_clk(core_clk), .rst_n(rst_n), .smbClkIn(scl), .smbDataIn(sda),
		.smbDataOut(sdaOut), .smbDataOe(sdaOe), .cellAttachedIn(cellIn),
		.warmSensorIn(warmIn), .sensorUnderrangeIn(underIn), .voltLoopLowIn(loopIn),
		.clampActiveIn(clampIn), .supplyLossIn(lossIn), .rangeStrap(strap),
		.voltDacCode(dac), .voltsOverrange(ovr), .voltsNotRegulated(notReg),
		.currentLimit(lim), .trickleCode(trk), .trickleOn(trkOn), .switcherOn(swOn),
		.chargingSuppressed(supp), .overtempHaltEnable(halt), .warmLatched(warmL),
		.alarmLockout(lock), .thermalStop(tStop), .eventPulse(evt));
	ccr_smb_host u_ccr_smb_host (.core_clk(core_clk), .sdaLevel(sda), .sclOut(scl),
		.sdaLow(sdaLow));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (90000) @(posedge core_clk);
		err_count++;
		$display("wrong value at %0t: run timed out", $time);
		test_done();
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [10:0] exp_volt(input logic [15:0] v);
		return (v[15] | v[14]) ? 11'h7ff : {1'b0, v[13:4]};
	endfunction
	function automatic logic [6:0] exp_trk(input logic kill, input logic cut,
		input logic [15:0] c);
		if (kill) begin
			return 7'h00;
		end
		return {~cut, c >= 16'h0020, cut ? 5'h00 : ((c >= 16'h0020) ? 5'h1f : c[4:0])};
	endfunction
	// Unused bits carry their fixed values
	function automatic logic [15:0] ctrl(input logic sup, rst, am, sm, hlt);
		return {5'h1f, hlt, 3'h7, sm, am, 2'b10, rst, 1'b0, sup};
	endfunction
	// Settles past sync and register stages
	task automatic check_all(input logic killExt, input logic cut);
		logic [15:0] mx;
		logic [6:0] t;
		tick(8);
		mx = (strap == 2'b00) ? 16'h03ff : ((strap == 2'b10) ? 16'h0fff : 16'h07ff);
		t = exp_trk(killExt | (curC == 16'h0000) | (curV < 16'h0010), cut, curC);
		chk({5'h00, ovr, dac}, {5'h00, exp_volt(curV)});
		chk({9'h000, trkOn, swOn, trk}, {9'h000, t});
		chk(lim, (curC > mx) ? mx : curC);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
		input logic [3:0] ea);
		logic [3:0] ack;
		u_ccr_smb_host.write_word(a, cmd, d, ack);
		chk({12'h000, ack}, {12'h000, ea});
		chk({15'h0000, sdaOut}, 16'h0000);
	endtask
	task automatic pulse(input logic exp);
		logic s;
		s = 1'b0;
		for (int i = 0; i < 10; i++) begin
			tick(1);
			s = s | evt;
		end
		chk({15'h0000, s}, {15'h0000, exp});
	endtask
	initial begin
		seed = 87636;
		err_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		cellIn = 1'b1;
		{warmIn, underIn, loopIn, clampIn, lossIn} = 5'h00;
		strap = 2'b00;
		curV = 16'hfff0;
		curC = 16'h000c;
		repeat (3) @(posedge core_clk);
		tick(1);
		rst_n = 1'b1;
		tick(10);
		chk({15'h0000, halt}, 16'h0001);
		chk({15'h0000, supp}, 16'h0000);
		check_all(1'b0, 1'b0);
		for (int i = 0; i < 9; i++) begin
			curV = (i < 5) ? vl[i] : 16'($random(seed));
			wr(7'h09, 8'h15, curV, 4'hf);
			check_all(1'b0, 1'b0);
		end
		for (int i = 0; i < 12; i++) begin
			strap = 2'(i % 4);
			curC = (i < 5) ? cl[i] : 16'($random(seed));
			wr(7'h09, 8'h14, curC, 4'hf);
			check_all(1'b0, 1'b0);
		end
		curV = 16'h2000;
		curC = 16'h0010;
		wr(7'h09, 8'h15, curV, 4'hf);
		wr(7'h09, 8'h14, curC, 4'hf);
		wr(7'h0a, 8'h15, 16'h1000, 4'h0);
		wr(7'h09, 8'h13, 16'h1000, 4'h8);
		check_all(1'b0, 1'b0);
		wr(7'h09, 8'h12, ctrl(1, 0, 0, 1, 1), 4'hf);
		chk({15'h0000, supp}, 16'h0001);
		check_all(1'b1, 1'b0);
		wr(7'h09, 8'h12, ctrl(0, 0, 0, 1, 1), 4'hf);
		check_all(1'b0, 1'b0);
		warmIn = 1'b1;
		check_all(1'b1, 1'b0);
		chk({15'h0000, tStop}, 16'h0001);
		chk({15'h0000, warmL}, 16'h0001);
		underIn = 1'b1;
		check_all(1'b0, 1'b0);
		underIn = 1'b0;
		warmIn = 1'b0;
		wr(7'h09, 8'h12, ctrl(0, 0, 0, 1, 0), 4'hf);
		check_all(1'b0, 1'b0);
		chk({15'h0000, halt}, 16'h0000);
		cellIn = 1'b0;
		pulse(1'b1);
		curV = 16'hfff0;
		curC = 16'h000c;
		chk({15'h0000, halt}, 16'h0001);
		check_all(1'b0, 1'b0);
		cellIn = 1'b1;
		pulse(1'b1);
		wr(7'h09, 8'h16, 16'h1000, 4'hf);
		chk({15'h0000, lock}, 16'h0001);
		check_all(1'b1, 1'b0);
		// Latch the warm flag so the restore has something to clear
		warmIn = 1'b1;
		tick(4);
		warmIn = 1'b0;
		tick(4);
		chk({15'h0000, warmL}, 16'h0001);
		wr(7'h09, 8'h12, ctrl(0, 1, 1, 1, 1), 4'hf);
		curV = 16'hffff;
		curC = 16'h00c0;
		chk({15'h0000, lock}, 16'h0000);
		chk({15'h0000, warmL}, 16'h0000);
		check_all(1'b0, 1'b0);
		loopIn = 1'b1;
		check_all(1'b0, 1'b1);
		clampIn = 1'b1;
		check_all(1'b0, 1'b0);
		chk({15'h0000, notReg}, 16'h0001);
		loopIn = 1'b0;
		clampIn = 1'b0;
		cellIn = 1'b0;
		pulse(1'b0);
		cellIn = 1'b1;
		pulse(1'b0);
		lossIn = 1'b1;
		pulse(1'b0);
		wr(7'h09, 8'h12, ctrl(0, 0, 1, 0, 1), 4'hf);
		lossIn = 1'b0;
		pulse(1'b1);
		test_done();
	end
endmodule // tb_charger_command_registers
`default_nettype wire
